/* evu_pkg.sv */
package evu_pkg;
   // status word layout
   localparam int          SW_W         = 16;
   localparam int          SW_SUPER_BIT = 13;
   localparam int          SW_IPL_LO    = 8;
   localparam logic [15:0] SW_RESET     = 16'h2700;
   // vector numbers
   localparam logic [7:0]  VEC_RESET_SSP  = 8'h00;
   localparam logic [7:0]  VEC_RESET_PC   = 8'h01;
   localparam logic [7:0]  VEC_BUS_ERR    = 8'h02;
   localparam logic [7:0]  VEC_ADDR_ERR   = 8'h03;
   localparam logic [7:0]  VEC_ILLEGAL    = 8'h04;
   localparam logic [7:0]  VEC_ZERO_DIV   = 8'h05;
   localparam logic [7:0]  VEC_BOUNDS     = 8'h06;
   localparam logic [7:0]  VEC_OVF_TRAP   = 8'h07;
   localparam logic [7:0]  VEC_PRIV       = 8'h08;
   localparam logic [7:0]  VEC_TRACE      = 8'h09;
   localparam logic [7:0]  VEC_LINE1010   = 8'h0A;
   localparam logic [7:0]  VEC_AUTO_BASE  = 8'h18;
   localparam logic [7:0]  VEC_UNINIT     = 8'h0F;
   // exception cause codes (index = vector number for internal causes)
   localparam logic [3:0]  CAUSE_INTR     = 4'hF;
   // vector sizes in words
   localparam logic [2:0]  VEC_WORDS      = 3'h2;
   localparam logic [2:0]  RESET_WORDS    = 3'h4;
   // function codes: supervisor data / supervisor program / int ack
   localparam logic [2:0]  FC_SUP_DATA    = 3'h5;
   localparam logic [2:0]  FC_SUP_PROG    = 3'h6;
   localparam logic [2:0]  FC_INT_ACK     = 3'h7;
   // operand sizes
   localparam logic [1:0]  SZ_BYTE        = 2'h0;
   localparam logic [1:0]  SZ_WORD        = 2'h1;
   localparam logic [1:0]  SZ_LONG        = 2'h2;
   // addressing modes
   localparam logic [3:0]  AM_DATA_DIR    = 4'h0;
   localparam logic [3:0]  AM_ADDR_DIR    = 4'h1;
   localparam logic [3:0]  AM_ABS_SHORT   = 4'h2;
   localparam logic [3:0]  AM_ABS_LONG    = 4'h3;
   localparam logic [3:0]  AM_PC_D16      = 4'h4;
   localparam logic [3:0]  AM_PC_IDX      = 4'h5;
   localparam logic [3:0]  AM_IND         = 4'h6;
   localparam logic [3:0]  AM_POSTINC     = 4'h7;
   localparam logic [3:0]  AM_PREDEC      = 4'h8;
   localparam logic [3:0]  AM_IND_D16     = 4'h9;
   localparam logic [3:0]  AM_IND_IDX     = 4'hA;
   localparam logic [3:0]  AM_IMM         = 4'hB;
   localparam logic [3:0]  AM_QUICK       = 4'hC;
   localparam logic [3:0]  AM_IMPLIED     = 4'hD;
   localparam logic [2:0]  SP_REG_NUM     = 3'h7;
   // status-word writing instructions
   localparam logic [2:0]  SWOP_NONE      = 3'h0;
   localparam logic [2:0]  SWOP_RETURN    = 3'h1;
   localparam logic [2:0]  SWOP_MOVE      = 3'h2;
   localparam logic [2:0]  SWOP_AND       = 3'h3;
   localparam logic [2:0]  SWOP_XOR       = 3'h4;
   localparam logic [2:0]  SWOP_OR        = 3'h5;
endpackage : evu_pkg

/* evu_exception_unit.sv */
// Behaviour
// - in user state only exception processing changes privilege state
// - exception entry saves supervisor flag, then sets it
// - supervisor to user only via return, move, and-imm, xor-imm to status word
// - step one copies status word and sets it up; step two finds vector
// - step three saves context; step four loads new context and resumes
// - vectors are two words long; the reset vector is four words
// - vectors fetched from supervisor data space; reset from supervisor program
// - table offset is the 8-bit vector number times four
// - vector number comes from internal logic or external source per cause
// - auto vector request selects the autovector of the pending level
// - reset fetches initial supervisor stack pointer from vector 0, offset 000
// - reset fetches initial program counter from vector 1, offset 004
// - vectors 2 to 10 serve fixed internal causes at offsets 008 to 028
// - operands are bytes, words or long words
// - effective address formed for all 14 addressing modes
// - post/pre step by 1, 2, 4; byte through stack pointer steps 2
`timescale 1ns/100ps
`default_nettype none
module evu_exception_unit (
   input  wire logic        CLK_SYS,      // 10 MHz system clock
   input  wire logic        RESETN,       // async reset, active low
   input  wire logic        EXC_REQ,      // internal exception request pulse
   input  wire logic [3:0]  EXC_CAUSE,    // vector number 2..10 or interrupt code
   input  wire logic [2:0]  INT_LEVEL,    // pending interrupt priority level
   input  wire logic [7:0]  VEC_DATA,     // low data lines during acknowledge
   input  wire logic        XFER_ACK,     // transfer_acknowledge from peripheral
   input  wire logic        AUTO_VEC_REQ, // auto_vector_request from peripheral
   input  wire logic        CTX_DONE,     // context save complete
   input  wire logic        FETCH_DONE,   // vector fetch complete
   input  wire logic [2:0]  SW_OP,        // status-word writing instruction
   input  wire logic [15:0] SW_WDATA,     // operand for status-word write
   input  wire logic [3:0]  EA_MODE,      // addressing mode
   input  wire logic [1:0]  EA_SIZE,      // operand size
   input  wire logic [2:0]  EA_REG,       // address register number
   input  wire logic [31:0] EA_BASE,      // addr_reg, pc or data_reg contents
   input  wire logic [31:0] EA_INDEX,     // index_reg contents
   input  wire logic [15:0] EA_EXT0,      // first extension word
   input  wire logic [15:0] EA_EXT1,      // second extension word
   output logic [15:0]      STATUS_WORD,  // current status word
   output logic [15:0]      SW_SAVED,     // temporary copy taken at entry
   output logic             SUPER,        // supervisor state
   output logic             IACK,         // interrupt acknowledge cycle active
   output logic             CTX_SAVE,     // step three active
   output logic             VEC_FETCH,    // step four vector fetch active
   output logic [7:0]       VEC_NUM,      // resolved vector number
   output logic [9:0]       VEC_OFFSET,   // vector number times four
   output logic [2:0]       VEC_FC,       // address space of vector fetch
   output logic [2:0]       VEC_LEN,      // vector length in words
   output logic             RESUME,       // pulse: back to instruction processing
   output logic [31:0]      EA_ADDR,      // effective address
   output logic [31:0]      EA_REG_NEW,   // updated address register
   output logic             EA_REG_WR     // address register update valid
);
   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_IDLE  = 3'b001,
      ST_SETUP = 3'b010,
      ST_VEC   = 3'b011,
      ST_SAVE  = 3'b100,
      ST_FETCH = 3'b101
   } evu_state_t;

   typedef struct packed {
      evu_state_t  st;
      logic [15:0] sw;
      logic [15:0] sw_tmp;
      logic [3:0]  cause;
      logic        iack;
      logic        ctx;
      logic        fetch;
      logic [7:0]  vnum;
      logic [9:0]  voff;
      logic [2:0]  vfc;
      logic [2:0]  vlen;
      logic        resume;
      logic [31:0] ea;
      logic [31:0] an_new;
      logic        an_wr;
   } evu_regs_t;

   evu_regs_t r_reg;
   evu_regs_t r_next;

   // operand step for post/pre modes
   function automatic logic [31:0] step_size(input logic [1:0] sz, input logic [2:0] rn);
      case (sz)
         evu_pkg::SZ_BYTE: step_size = (rn == evu_pkg::SP_REG_NUM) ? 32'h2 : 32'h1;
         evu_pkg::SZ_WORD: step_size = 32'h2;
         evu_pkg::SZ_LONG: step_size = 32'h4;
         default:          step_size = 32'h2;
      endcase
   endfunction : step_size

   function automatic logic [31:0] sext16(input logic [15:0] v);
      sext16 = {{16{v[15]}}, v};
   endfunction : sext16

   function automatic logic [31:0] sext8(input logic [7:0] v);
      sext8 = {{24{v[7]}}, v};
   endfunction : sext8

   logic [31:0] step;
   assign step = step_size(EA_SIZE, EA_REG);

   always_comb begin
      logic [15:0] sw_w;
      sw_w = r_reg.sw;
      r_next = r_reg;
      r_next.resume = 1'b0;
      r_next.an_wr = 1'b0;
      // effective address for all modes
      case (EA_MODE)
         evu_pkg::AM_DATA_DIR,
         evu_pkg::AM_ADDR_DIR,
         evu_pkg::AM_IND:       r_next.ea = EA_BASE;
         evu_pkg::AM_ABS_SHORT: r_next.ea = sext16(EA_EXT0);
         evu_pkg::AM_ABS_LONG:  r_next.ea = {EA_EXT0, EA_EXT1};
         evu_pkg::AM_PC_D16,
         evu_pkg::AM_IND_D16:   r_next.ea = EA_BASE + sext16(EA_EXT0);
         evu_pkg::AM_PC_IDX,
         evu_pkg::AM_IND_IDX:   r_next.ea = EA_BASE + EA_INDEX + sext8(EA_EXT0[7:0]);
         evu_pkg::AM_POSTINC: begin
            r_next.ea = EA_BASE;
            r_next.an_new = EA_BASE + step;
            r_next.an_wr = 1'b1;
         end
         evu_pkg::AM_PREDEC: begin
            r_next.ea = EA_BASE - step;
            r_next.an_new = EA_BASE - step;
            r_next.an_wr = 1'b1;
         end
         evu_pkg::AM_IMM,
         evu_pkg::AM_QUICK,
         evu_pkg::AM_IMPLIED:   r_next.ea = EA_BASE;
         default:               r_next.ea = 32'h0;
      endcase
      // status-word writes, all bits in supervisor state, low byte only in user state
      case (SW_OP)
         evu_pkg::SWOP_RETURN,
         evu_pkg::SWOP_MOVE:   sw_w = SW_WDATA;
         evu_pkg::SWOP_AND:    sw_w = r_reg.sw & SW_WDATA;
         evu_pkg::SWOP_XOR:    sw_w = r_reg.sw ^ SW_WDATA;
         evu_pkg::SWOP_OR:     sw_w = r_reg.sw | SW_WDATA;
         default:              sw_w = r_reg.sw;
      endcase
      // or-immediate can never clear supervisor flag
      if (SW_OP == evu_pkg::SWOP_OR) begin
         sw_w[evu_pkg::SW_SUPER_BIT] = r_reg.sw[evu_pkg::SW_SUPER_BIT];
      end
      case (r_reg.st)
         ST_RESET: begin
            r_next.vnum = evu_pkg::VEC_RESET_SSP;
            r_next.voff = {r_next.vnum, 2'b00};
            r_next.vfc = evu_pkg::FC_SUP_PROG;
            r_next.vlen = evu_pkg::RESET_WORDS;
            r_next.fetch = 1'b1;
            if (FETCH_DONE && r_reg.fetch) begin
               if (r_reg.vnum == evu_pkg::VEC_RESET_SSP) begin
                  r_next.vnum = evu_pkg::VEC_RESET_PC;
                  r_next.voff = {evu_pkg::VEC_RESET_PC, 2'b00};
               end else begin
                  r_next.vnum = r_reg.vnum;
                  r_next.voff = r_reg.voff;
                  r_next.fetch = 1'b0;
                  r_next.resume = 1'b1;
                  r_next.st = ST_IDLE;
               end
            end else begin
               r_next.vnum = r_reg.vnum;
               r_next.voff = r_reg.voff;
            end
         end
         ST_IDLE: begin
            if (r_reg.sw[evu_pkg::SW_SUPER_BIT]) begin
               r_next.sw = sw_w;
            end else begin
               // user state: only non-privilege bits may change
               r_next.sw = {r_reg.sw[15:8], sw_w[7:0]};
            end
            if (EXC_REQ) begin
               r_next.cause = EXC_CAUSE;
               r_next.st = ST_SETUP;
            end
         end
         ST_SETUP: begin
            r_next.sw_tmp = r_reg.sw;
            r_next.sw[evu_pkg::SW_SUPER_BIT] = 1'b1;
            r_next.st = ST_VEC;
            r_next.iack = (r_reg.cause == evu_pkg::CAUSE_INTR);
            if (r_reg.cause == evu_pkg::CAUSE_INTR) begin
               r_next.sw[evu_pkg::SW_IPL_LO +: 3] = INT_LEVEL;
            end
         end
         ST_VEC: begin
            if (!r_reg.iack) begin
               r_next.vnum = {4'h0, r_reg.cause};
               r_next.st = ST_SAVE;
            end else if (AUTO_VEC_REQ) begin
               r_next.vnum = evu_pkg::VEC_AUTO_BASE + {5'h00, INT_LEVEL};
               r_next.iack = 1'b0;
               r_next.st = ST_SAVE;
            end else if (XFER_ACK) begin
               r_next.vnum = VEC_DATA;
               r_next.iack = 1'b0;
               r_next.st = ST_SAVE;
            end
            r_next.voff = {r_next.vnum, 2'b00};
            r_next.vfc = evu_pkg::FC_SUP_DATA;
            r_next.vlen = evu_pkg::VEC_WORDS;
            r_next.ctx = (r_next.st == ST_SAVE);
         end
         ST_SAVE: begin
            if (CTX_DONE) begin
               r_next.ctx = 1'b0;
               r_next.fetch = 1'b1;
               r_next.st = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (FETCH_DONE) begin
               r_next.fetch = 1'b0;
               r_next.resume = 1'b1;
               r_next.st = ST_IDLE;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         r_reg <= '{st: ST_RESET, sw: evu_pkg::SW_RESET, vnum: evu_pkg::VEC_RESET_SSP,
                    vfc: evu_pkg::FC_SUP_PROG, vlen: evu_pkg::RESET_WORDS, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign STATUS_WORD = r_reg.sw;
   assign SW_SAVED    = r_reg.sw_tmp;
   assign SUPER       = r_reg.sw[evu_pkg::SW_SUPER_BIT];
   assign IACK        = r_reg.iack;
   assign CTX_SAVE    = r_reg.ctx;
   assign VEC_FETCH   = r_reg.fetch;
   assign VEC_NUM     = r_reg.vnum;
   assign VEC_OFFSET  = r_reg.voff;
   assign VEC_FC      = r_reg.vfc;
   assign VEC_LEN     = r_reg.vlen;
   assign RESUME      = r_reg.resume;
   assign EA_ADDR     = r_reg.ea;
   assign EA_REG_NEW  = r_reg.an_new;
   assign EA_REG_WR   = r_reg.an_wr;

   property p_user_stays;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_IDLE && !SUPER) |=> !SUPER;
   endproperty
   a_user_stays: assert property (p_user_stays) else $error("user state left");

   property p_entry_super;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_SETUP) |=> SUPER && SW_SAVED == $past(STATUS_WORD);
   endproperty
   a_entry_super: assert property (p_entry_super) else $error("flag not saved and set");

   property p_drop_super;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (SUPER ##1 !SUPER) |-> $past(SW_OP) inside {evu_pkg::SWOP_RETURN, evu_pkg::SWOP_MOVE,
                                                 evu_pkg::SWOP_AND, evu_pkg::SWOP_XOR};
   endproperty
   a_drop_super: assert property (p_drop_super) else $error("illegal drop to user");

   sequence s_setup;
      r_reg.st == ST_SETUP;
   endsequence
   property p_steps;
      @(posedge CLK_SYS) disable iff (!RESETN)
      s_setup |=> r_reg.st == ST_VEC;
   endproperty
   a_steps: assert property (p_steps) else $error("step two did not follow step one");

   property p_resume;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_FETCH && FETCH_DONE) |=> RESUME && !VEC_FETCH;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after fetch");

   property p_offset;
      @(posedge CLK_SYS) disable iff (!RESETN)
      VEC_FETCH |-> VEC_OFFSET == {VEC_NUM, 2'b00};
   endproperty
   a_offset: assert property (p_offset) else $error("offset not vector times four");

   property p_space;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_FETCH) |-> VEC_FC == evu_pkg::FC_SUP_DATA && VEC_LEN == 3'h2;
   endproperty
   a_space: assert property (p_space) else $error("bad vector space or size");

   property p_autovec;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_VEC && IACK && AUTO_VEC_REQ) |=> VEC_NUM == 8'h18 + $past(INT_LEVEL);
   endproperty
   a_autovec: assert property (p_autovec) else $error("wrong autovector");

   property p_postinc;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (EA_MODE == evu_pkg::AM_POSTINC && EA_SIZE == evu_pkg::SZ_BYTE && EA_REG == 3'h7)
         |=> EA_REG_NEW == $past(EA_BASE) + 32'h2;
   endproperty
   a_postinc: assert property (p_postinc) else $error("stack byte step not two");

   property p_reset_space;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_RESET) |-> VEC_FC == evu_pkg::FC_SUP_PROG
         && VEC_LEN == evu_pkg::RESET_WORDS;
   endproperty
   a_reset_space: assert property (p_reset_space) else $error("bad reset space");

   property p_reset_pc;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_RESET && VEC_FETCH && FETCH_DONE && VEC_NUM == evu_pkg::VEC_RESET_SSP)
         |=> VEC_NUM == evu_pkg::VEC_RESET_PC && VEC_OFFSET == 10'h004 && VEC_FETCH;
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("no move to vector 1");

   property p_vec_data;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == ST_VEC && IACK && XFER_ACK && !AUTO_VEC_REQ)
         |=> VEC_NUM == $past(VEC_DATA) && !IACK && CTX_SAVE;
   endproperty
   a_vec_data: assert property (p_vec_data) else $error("vector byte not taken");

   property p_abs_long;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (EA_MODE == evu_pkg::AM_ABS_LONG) |=> EA_ADDR == {$past(EA_EXT0), $past(EA_EXT1)};
   endproperty
   a_abs_long: assert property (p_abs_long) else $error("bad absolute long address");

   property p_ctx_hold;
      @(posedge CLK_SYS) disable iff (!RESETN)
      (CTX_SAVE && !CTX_DONE) |=> CTX_SAVE;
   endproperty
   a_ctx_hold: assert property (p_ctx_hold) else $error("context save dropped early");
endmodule : evu_exception_unit
`default_nettype wire

/* evu_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none
module evu_periph_model (
   input  wire logic       clk,          // system clock
   input  wire logic       resetn,       // async reset, active low
   input  wire logic       iack,         // acknowledge cycle from core
   input  wire logic       use_auto,     // answer with autovector request
   input  wire logic [3:0] delay,        // wait cycles before answering
   input  wire logic [7:0] vec_in,       // vector byte to supply
   output logic            xfer_ack,     // transfer_acknowledge
   output logic            auto_vec_req, // auto_vector_request
   output logic [7:0]      vec_data      // low data lines
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg      <= 4'h0;
         xfer_ack     <= 1'b0;
         auto_vec_req <= 1'b0;
         vec_data     <= 8'hA5;
      end else if (!iack) begin
         cnt_reg      <= 4'h0;
         xfer_ack     <= 1'b0;
         auto_vec_req <= 1'b0;
         vec_data     <= ~vec_data; // released lines toggle, so the stale vector returns every other cycle
      end else if (!xfer_ack && !auto_vec_req) begin
         vec_data <= ~vec_data;
         if (cnt_reg == delay) begin
            auto_vec_req <= use_auto;
            xfer_ack     <= !use_auto;
            if (!use_auto) begin
               vec_data <= vec_in;
            end
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule : evu_periph_model
`default_nettype wire

/* evu_exception_unit_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module evu_exception_unit_tb_top;
   logic clk_sys, resetn, exc_req, xfer_ack, auto_vec_req, ctx_done, fetch_done, p_auto;
   logic sup_st, iack, ctx_save, vec_fetch, resume, ea_reg_wr;
   logic [3:0] exc_cause, ea_mode, p_delay;
   logic [2:0] int_level, sw_op, ea_reg, vec_fc, vec_len;
   logic [1:0] ea_size;
   logic [7:0] vec_data, vec_num, p_vec;
   logic [9:0] vec_offset;
   logic [15:0] sw_wdata, ea_ext0, ea_ext1, status_word, sw_saved, sw_exp;
   logic [31:0] ea_base, ea_index, ea_addr, ea_reg_new;
   int n_errors = 0;
   int num_checks = 0;
   int rc;
   logic [2:0] ops [4] = '{evu_pkg::SWOP_MOVE, evu_pkg::SWOP_AND, evu_pkg::SWOP_XOR,
                           evu_pkg::SWOP_RETURN};
   logic [15:0] msk [4] = '{16'h0700, 16'hDFFF, 16'h2000, 16'h0300};

   evu_exception_unit evu_exception_unit_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
      .EXC_REQ(exc_req), .EXC_CAUSE(exc_cause), .INT_LEVEL(int_level), .VEC_DATA(vec_data),
      .XFER_ACK(xfer_ack), .AUTO_VEC_REQ(auto_vec_req), .CTX_DONE(ctx_done),
      .FETCH_DONE(fetch_done), .SW_OP(sw_op), .SW_WDATA(sw_wdata), .EA_MODE(ea_mode),
      .EA_SIZE(ea_size), .EA_REG(ea_reg), .EA_BASE(ea_base), .EA_INDEX(ea_index),
      .EA_EXT0(ea_ext0), .EA_EXT1(ea_ext1), .STATUS_WORD(status_word), .SW_SAVED(sw_saved),
      .SUPER(sup_st), .IACK(iack), .CTX_SAVE(ctx_save), .VEC_FETCH(vec_fetch),
      .VEC_NUM(vec_num), .VEC_OFFSET(vec_offset), .VEC_FC(vec_fc), .VEC_LEN(vec_len),
      .RESUME(resume), .EA_ADDR(ea_addr), .EA_REG_NEW(ea_reg_new), .EA_REG_WR(ea_reg_wr));
   evu_periph_model evu_periph_model_inst (.clk(clk_sys), .resetn(resetn), .iack(iack),
      .use_auto(p_auto), .delay(p_delay), .vec_in(p_vec), .xfer_ack(xfer_ack),
      .auto_vec_req(auto_vec_req), .vec_data(vec_data));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic wrap_up;
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic pick(input int w);
      case (w)
         0: return ctx_save;
         1: return vec_fetch;
         default: return resume;
      endcase
   endfunction : pick

   task automatic wait_for(input int w);
      int i;
      for (i = 0; i < 40; i++) begin
         // look first: a one-cycle pulse may already stand
         #1;
         if (pick(w) === 1'b1) break;
         @(posedge clk_sys);
      end
      chk(i < 40, 1'b1);
   endtask : wait_for

   task automatic pulse(input int w);
      @(posedge clk_sys);
      if (w == 0) ctx_done <= 1'b1;
      else fetch_done <= 1'b1;
      @(posedge clk_sys);
      ctx_done <= 1'b0;
      fetch_done <= 1'b0;
   endtask : pulse

   function automatic logic [15:0] exp_sw(input logic [15:0] s, input logic [2:0] op,
                                          input logic [15:0] w);
      logic [15:0] r;
      case (op)
         evu_pkg::SWOP_RETURN, evu_pkg::SWOP_MOVE: r = w;
         evu_pkg::SWOP_AND: r = s & w;
         evu_pkg::SWOP_XOR: r = s ^ w;
         evu_pkg::SWOP_OR: r = {s[15:14], s[13], s[12:0] | w[12:0]} | (w & 16'hC000);
         default: r = s;
      endcase
      if (!s[13]) r = {s[15:8], r[7:0]};
      return r;
   endfunction : exp_sw

   task automatic swop(input logic [2:0] op, input logic [15:0] w);
      logic [15:0] e;
      e = exp_sw(sw_exp, op, w);
      @(posedge clk_sys);
      sw_op <= op;
      sw_wdata <= w;
      @(posedge clk_sys);
      sw_op <= evu_pkg::SWOP_NONE;
      #1;
      chk(status_word, e);
      chk(sup_st, e[13]);
      sw_exp = e;
   endtask : swop

   task automatic run_exc(input logic [3:0] cause, input logic [7:0] ev);
      @(posedge clk_sys);
      exc_req <= 1'b1;
      exc_cause <= cause;
      @(posedge clk_sys);
      exc_req <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(iack, cause == evu_pkg::CAUSE_INTR);
      wait_for(0);
      chk(sup_st, 1'b1);
      chk({sw_saved[13], sw_saved[7:0]}, {sw_exp[13], sw_exp[7:0]});
      chk(vec_num, ev);
      chk(vec_offset, {ev, 2'b00});
      chk(vec_fc, evu_pkg::FC_SUP_DATA);
      chk(vec_len, evu_pkg::VEC_WORDS);
      @(posedge clk_sys);
      exc_req <= 1'b1;
      exc_cause <= evu_pkg::VEC_ILLEGAL[3:0];
      @(posedge clk_sys);
      exc_req <= 1'b0;
      pulse(0);
      wait_for(1);
      chk({ctx_save, vec_num}, {1'b0, ev});
      pulse(1);
      wait_for(2);
      sw_exp[13] = 1'b1;
   endtask : run_exc

   task automatic ea_run(input logic [3:0] m, input logic [1:0] s, input logic [2:0] r);
      logic [31:0] b, x, n;
      logic [15:0] e0, e1;
      b = $urandom;
      x = $urandom;
      e0 = 16'($urandom);
      e1 = 16'($urandom);
      n = (s == evu_pkg::SZ_BYTE) ? ((r == evu_pkg::SP_REG_NUM) ? 2 : 1) :
          (s == evu_pkg::SZ_WORD) ? 2 : 4;
      @(posedge clk_sys);
      {ea_mode, ea_size, ea_reg, ea_base, ea_index, ea_ext0, ea_ext1} <= {m, s, r, b, x, e0, e1};
      @(posedge clk_sys);
      #1;
      case (m)
         evu_pkg::AM_ABS_SHORT: chk(ea_addr, {{16{e0[15]}}, e0});
         evu_pkg::AM_ABS_LONG: chk(ea_addr, {e0, e1});
         evu_pkg::AM_PC_D16, evu_pkg::AM_IND_D16: chk(ea_addr, b + {{16{e0[15]}}, e0});
         evu_pkg::AM_PC_IDX, evu_pkg::AM_IND_IDX:
            chk(ea_addr, b + x + {{24{e0[7]}}, e0[7:0]});
         evu_pkg::AM_DATA_DIR, evu_pkg::AM_ADDR_DIR, evu_pkg::AM_IND, evu_pkg::AM_POSTINC:
            chk(ea_addr, b);
         evu_pkg::AM_PREDEC: chk(ea_addr, b - n);
         default: ;
      endcase
      if (m == evu_pkg::AM_POSTINC) chk(ea_reg_new, b + n);
      if (m == evu_pkg::AM_PREDEC) chk(ea_reg_new, b - n);
      chk(ea_reg_wr, m == evu_pkg::AM_POSTINC || m == evu_pkg::AM_PREDEC);
   endtask : ea_run

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      wrap_up();
   end

   initial begin
      {resetn, exc_req, ctx_done, fetch_done, p_auto} = '0;
      {exc_cause, int_level, sw_op, sw_wdata, ea_mode, ea_size, ea_reg} = '0;
      {ea_base, ea_index, ea_ext0, ea_ext1, p_delay, p_vec} = '0;
      sw_exp = evu_pkg::SW_RESET;
      void'($urandom(32'hCAFA));
      repeat (4) @(posedge clk_sys);
      chk({status_word, sup_st, vec_fetch}, {16'h2700, 1'b1, 1'b0});
      resetn <= 1'b1;
      wait_for(1);
      chk({vec_num, vec_offset, vec_fc, vec_len},
          {8'h00, 10'h000, 3'h6, 3'h4});
      pulse(1);
      wait_for(1);
      chk({vec_num, vec_offset, vec_fc, vec_len},
          {8'h01, 10'h004, 3'h6, 3'h4});
      pulse(1);
      wait_for(2);
      for (int c = 2; c <= 10; c++) run_exc(4'(c), 8'(c));
      for (int i = 0; i < 4; i++) begin
         swop(evu_pkg::SWOP_MOVE, 16'h2700 | 16'($urandom_range(255)));
         swop(evu_pkg::SWOP_OR, 16'($urandom));
         swop(ops[i], msk[i]);
         swop(evu_pkg::SWOP_MOVE, 16'h2700);
         swop(evu_pkg::SWOP_OR, 16'hFFFF);
         swop(evu_pkg::SWOP_RETURN, 16'h2755);
         rc = $urandom_range(10, 2);
         run_exc(4'(rc), 8'(rc));
      end
      for (int l = 0; l < 16; l++) begin
         int_level <= 3'(l);
         p_auto = (l < 8);
         p_delay = 4'($urandom_range(3));
         p_vec = 8'($urandom_range(255, 64));
         rc = p_auto ? evu_pkg::VEC_AUTO_BASE + 8'(l % 8) : p_vec;
         run_exc(evu_pkg::CAUSE_INTR, 8'(rc));
      end
      for (int k = 0; k < 240; k++) begin
         if (k < 42) ea_run(4'(k % 14), 2'(k / 14), evu_pkg::SP_REG_NUM);
         else ea_run(4'($urandom_range(13)), 2'($urandom_range(2)), 3'($urandom));
      end
      wrap_up();
   end
endmodule : evu_exception_unit_tb_top
`default_nettype wire
